// >>> shared/phase_link_if.sv
`timescale 1ns/100ps

interface phase_link_if;
  import sync_jitter_pkg::*;
  logic hd_fall;
  logic vd_fall;
  count_t pos;
  count_t len;
  phase_t phase;
  logic near;
  logic phase_valid;

  modport meter (
    input hd_fall,
    input vd_fall,
    output pos,
    output len,
    output phase,
    output near,
    output phase_valid
  );
  modport user (
    output hd_fall,
    output vd_fall,
    input pos,
    input len,
    input phase,
    input near,
    input phase_valid
  );
endinterface // phase_link_if

// >>> shared/sync_jitter_map.svh
`ifndef SYNC_JITTER_MAP_SVH
`define SYNC_JITTER_MAP_SVH

// register addresses on the plain register port
`define CTRL_OFS 16'h0fe4
`define STAT_OFS 16'h0fe5
`define READ_NONE 8'h00

// control register fields
`define JITTER_FILTER_ON_BIT 2
`define AUTO_FIELD_PICK_BIT 3
`define VSYNC_SOURCE_SEL_BIT 4

// status register fields
`define FIELD_PARITY_FLAG_BIT 7
`define PHASE_MSB 6
`define PHASE_LSB 4

// line timing: nominal line period in us, clock rate in MHz
`define LINE_US 64
`define CLK_MHZ 10
`define LINE_LEN_RST 12'(`LINE_US * `CLK_MHZ)
`define POS_MAX 12'hfff
`define PHASES 8
`define PHASE_W 3
`define COUNT_W 12

`endif

// >>> shared/sync_jitter_pkg.sv
`include "sync_jitter_map.svh"

package sync_jitter_pkg;

  typedef logic [`COUNT_W-1:0] count_t;
  typedef logic [`PHASE_W-1:0] phase_t;

  // internal vertical sync placement
  typedef enum logic [3:0] {
    ST_HIGH = 4'b0001,
    ST_WAIT_HD = 4'b0010,
    ST_WAIT_QTR = 4'b0100,
    ST_LOW = 4'b1000
  } jit_state_e;

  // quarter of a line period
  function automatic count_t quarter_of(count_t len);
    return {2'b00, len[`COUNT_W-1:2]};
  endfunction

  // true when pos is within a quarter line of a horizontal sync fall
  function automatic logic near_hd(count_t pos, count_t len);
    count_t q;
    q = quarter_of(len);
    return (pos < q) || (pos >= len - q);
  endfunction

  // phase in eighths of a line: number of boundaries pos has passed
  function automatic phase_t phase_of(count_t pos, count_t len);
    logic [`COUNT_W+2:0] scaled;
    logic [`COUNT_W+2:0] bound;
    phase_t ph;
    scaled = {pos, 3'b000};
    bound = '0;
    ph = '0;
    for (int k = 1; k < `PHASES; k++) begin
      bound = bound + {3'b000, len};
      if (scaled >= bound) begin
        ph = ph + 3'h1;
      end
    end
    return ph;
  endfunction

endpackage

// >>> tb/sync_jitter_chk.sv
`timescale 1ns/100ps
`include "sync_jitter_map.svh"

module sync_jitter_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // syncs and display outputs
  input wire logic horizontal_sync_in_n,
  input wire logic port_pin_vsync_n,
  input wire logic osd_hsync_n,
  input wire logic osd_vsync_n,
  input wire logic show_first_dot_lines,
  input wire logic show_second_dot_lines,
  input wire logic field_parity_flag,
  input wire sync_jitter_pkg::phase_t sync_phase_code
);
  logic [7:0] ctrl;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // shadow of the write-only control register
  always_ff @(posedge clk) begin
    if (!resetn) ctrl <= 8'h00;
    else if (reg_wr && reg_addr == `CTRL_OFS) ctrl <= reg_wdata;
  end

  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_status_read: assert property (
    $past(reg_rd && reg_addr == `STAT_OFS)
    |-> reg_rdata == {$past(field_parity_flag), $past(sync_phase_code),
    4'h0}) else $error("status read wrong");
  chk_other_read: assert property (
    $past(reg_rd && reg_addr != `STAT_OFS)
    |-> reg_rdata == 8'h00) else $error("non status read not zero");
  chk_status_hold: assert property ((port_pin_vsync_n && !reg_wr)[*6]
    |=> $stable(sync_phase_code) && $stable(field_parity_flag))
    else $error("status changed between vsyncs");
  chk_pin_source: assert property ((!ctrl[`VSYNC_SOURCE_SEL_BIT]
    && $stable(port_pin_vsync_n))[*6] |-> osd_vsync_n == port_pin_vsync_n)
    else $error("vsync not from pin");
  chk_show_manual: assert property (
    ($stable(ctrl) && !ctrl[`AUTO_FIELD_PICK_BIT])[*3]
    |-> show_second_dot_lines && show_first_dot_lines == !ctrl[`JITTER_FILTER_ON_BIT])
    else $error("manual show lines wrong");
  chk_show_auto: assert property ((ctrl[`AUTO_FIELD_PICK_BIT] && $stable(ctrl)
    && $stable(field_parity_flag))[*3] |-> show_first_dot_lines ==
    field_parity_flag && show_second_dot_lines == !field_parity_flag)
    else $error("auto show lines wrong");
  chk_parity_off: assert property (
    ($stable(ctrl) && !ctrl[`AUTO_FIELD_PICK_BIT])[*3]
    |-> !field_parity_flag) else $error("parity set without auto");
  chk_hsync_pass: assert property ($stable(horizontal_sync_in_n)[*4]
    |-> osd_hsync_n == horizontal_sync_in_n) else $error("hsync not passed");
endmodule // sync_jitter_chk

bind sync_jitter_field_decision sync_jitter_chk chk_i (.clk(clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .horizontal_sync_in_n(horizontal_sync_in_n),
  .port_pin_vsync_n(port_pin_vsync_n), .osd_hsync_n(osd_hsync_n),
  .osd_vsync_n(osd_vsync_n), .show_first_dot_lines(show_first_dot_lines),
  .show_second_dot_lines(show_second_dot_lines),
  .field_parity_flag(field_parity_flag), .sync_phase_code(sync_phase_code));

// >>> tb/sync_source.sv
`timescale 1ns/100ps

module sync_source #(parameter int LINE = 64) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // frame request
  input wire logic go,
  input wire logic [7:0] off,
  // sync pins
  output logic hs_n,
  output logic vs_n
);
  logic [7:0] pos;
  logic [7:0] low;
  logic armed;

  // free running lines, one vsync pulse of two lines per request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos <= 8'h00;
      hs_n <= 1'b1;
      vs_n <= 1'b1;
      armed <= 1'b0;
      low <= 8'h00;
    end else begin
      pos <= (pos == 8'(LINE - 1)) ? 8'h00 : pos + 8'h01;
      hs_n <= !(pos == 8'(LINE - 1) || pos < 8'h03); // line start
      if (go) armed <= 1'b1;
      if (armed && pos == off) begin
        vs_n <= 1'b0;
        armed <= 1'b0;
        low <= 8'(2 * LINE);
      end else if (low != 8'h00) begin
        low <= low - 8'h01;
        vs_n <= (low == 8'h01);
      end
    end
  end
endmodule // sync_source

// >>> tb/tb_sync_jitter_field_decision.sv
`timescale 1ns/100ps
`include "sync_jitter_map.svh"

module tb_sync_jitter_field_decision;
  import sync_jitter_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, go, hs_n, vs_n, oh, ov, sf, ss, par;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, rdata, off;
  phase_t code;
  int failures, checked;
  int hpos = 0;
  int vpos = 0;

  sync_jitter_field_decision uut (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .horizontal_sync_in_n(hs_n),
    .port_pin_vsync_n(vs_n), .osd_hsync_n(oh), .osd_vsync_n(ov),
    .show_first_dot_lines(sf), .show_second_dot_lines(ss),
    .field_parity_flag(par), .sync_phase_code(code));
  sync_source src (.clk(clk), .resetn(resetn), .go(go), .off(off),
    .hs_n(hs_n), .vs_n(vs_n));

  // status byte for a phase; parity only away from the hsync fall
  function automatic logic [7:0] exp_stat(int ph, logic auto_on);
    return {auto_on && ph inside {[2:5]}, 3'(ph), 4'h0};
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [15:0] a, logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("rdata", rdata, exp);
    @(posedge clk);
  endtask

  task automatic frame(logic [7:0] o);
    off <= o;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (256) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // display vsync fall position counted from display hsync fall
  always @(posedge clk) begin
    hpos <= $fell(oh) ? 0 : hpos + 1;
    if ($fell(ov)) vpos <= hpos;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  // main sequence
  initial begin
    int ph, v0;
    logic p;
    {resetn, reg_wr, reg_rd, go, reg_addr, reg_wdata, off} = '0;
    {failures, checked} = '0;
    void'($urandom(32'ha657));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`STAT_OFS, 8'h00);
    rd(`CTRL_OFS, 8'h00);
    rd(16'h0123, 8'h00);
    wr(`CTRL_OFS, 8'h1f);
    wr(16'h0fe3, 8'h00);
    for (int i = 0; i < 24; i++) begin
      ph = (i < 8) ? i : int'($urandom % 8);
      p = ph inside {[2:5]};
      frame(8'(ph * 8 + 1 + int'($urandom % 5)));
      rd(`STAT_OFS, exp_stat(ph, 1'b1));
      check("show", {6'h0, sf, ss}, {6'h0, p, !p});
    end
    frame(8'd2);
    v0 = vpos;
    check("place", 8'(v0), 8'(64 / 4 + 1));
    frame(8'd12);
    check("place", 8'(vpos), 8'(v0));
    frame(8'd60);
    check("place", 8'(vpos), 8'(v0));
    wr(`CTRL_OFS, 8'h04);
    frame(8'd27);
    rd(`STAT_OFS, exp_stat(3, 1'b0));
    check("show", {6'h0, sf, ss}, 8'h01);
    wr(`CTRL_OFS, 8'h10);
    frame(8'd2);
    check("jitter off", 8'(vpos == v0), 8'h00);
    wr(`CTRL_OFS, 8'h00);
    frame(8'd27);
    check("show", {6'h0, sf, ss}, 8'h03);
    close_out();
  end
endmodule // tb_sync_jitter_field_decision

// >>> verilog/sync_jitter_field_decision.sv
// Contract
// R1 - parity flag 0 in second-dot field, 1 in first-dot field.
// R2 - phase between sync falls reported as 3-bit code 0 to 7.
// R3 - parity is an on-screen display field, not broadcast field identity.
// R4 - measure phase between vertical and horizontal sync falling edges.
// R5 - vsync falling within a quarter line of hsync gets a fixed position.
// R6 - software enables jitter removal via control bit 2.
// R7 - field line decisions come from the corrected internal syncs; code uses where the synchronised pin vsync fell.
// R8 - interlaced: all three bits set, both dot fields shown; code shows first-dot lines when parity is 1, second-dot when 0.
// R9 - non-interlaced: jitter on, auto and source clear, second dot only.
// R10 - double scan: all bits clear, both dot fields shown.
// R11 - source bit 0 takes pin vsync, 1 takes the corrected vsync.
// R12 - automatic field decision only while the auto bit is 1.
// R13 - phase and parity update per vsync fall, held between falls; parity also clears between falls when the auto bit is cleared.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module sync_jitter_field_decision (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sync pins
  input wire logic horizontal_sync_in_n,
  input wire logic port_pin_vsync_n,
  // to the on-screen display
  output logic osd_hsync_n,
  output logic osd_vsync_n,
  output logic show_first_dot_lines,
  output logic show_second_dot_lines,
  output logic field_parity_flag,
  output sync_jitter_pkg::phase_t sync_phase_code
);
  import sync_jitter_pkg::*;

  typedef struct packed {
    // pin synchronisers and edge history
    logic hd_s1;
    logic hd_s2;
    logic hd_q;
    logic vd_s1;
    logic vd_s2;
    logic vd_q;
    // write-only control bits
    logic jitter_filter_on;
    logic auto_field_pick;
    logic vsync_source_sel;
    // latched results and read data
    logic parity;
    phase_t phase;
    logic [7:0] rdata;
    // vsync placement and display outputs
    jit_state_e st;
    logic hsync_n;
    logic vsync_n;
    logic show_first;
    logic show_second;
  } core_s;

  // synchronisers reset to the idle high level of the pins
  localparam core_s CORE_RST = '{
    hd_s1: 1'b1, hd_s2: 1'b1, hd_q: 1'b1,
    vd_s1: 1'b1, vd_s2: 1'b1, vd_q: 1'b1,
    jitter_filter_on: 1'b0, auto_field_pick: 1'b0,
    vsync_source_sel: 1'b0, parity: 1'b0, phase: '0,
    rdata: `READ_NONE, st: ST_HIGH, hsync_n: 1'b1, vsync_n: 1'b1,
    show_first: 1'b1, show_second: 1'b1};

  // whole core state and its next value
  core_s r;
  core_s next_r;
  // the line meter sits behind this link
  phase_link_if link ();
  logic hd_fall;
  logic vd_fall;
  logic int_vsync_n;
  logic [7:0] status;
  count_t qtr;
  logic ctrl_wr;
  logic stat_rd;
  logic vd_near;
  logic vd_early;

  // edge detect behind the two-flop synchronisers
  assign hd_fall = r.hd_q & ~r.hd_s2;
  assign vd_fall = r.vd_q & ~r.vd_s2;
  assign link.hd_fall = hd_fall;
  assign link.vd_fall = vd_fall;
  assign qtr = quarter_of(link.len);

  // register port decode
  assign ctrl_wr = reg_wr && (reg_addr == `CTRL_OFS);
  assign stat_rd = reg_rd && (reg_addr == `STAT_OFS);

  // where the pin vsync fell against the line, for placement
  assign vd_near = near_hd(link.pos, link.len); // [R5]
  assign vd_early = link.pos < qtr; // fall before the quarter point

  // line position, length and phase of each vsync fall
  sync_phase_meter meter (
    .clk(clk),
    .resetn(resetn),
    .link(link)
  );

  // status image for reads
  always_comb begin
    status = `READ_NONE;
    status[`FIELD_PARITY_FLAG_BIT] = r.parity; // [R1]
    status[`PHASE_MSB:`PHASE_LSB] = r.phase; // [R2]
  end

  // corrected vsync follows the pin when the filter is off
  assign int_vsync_n = r.jitter_filter_on ? (r.st != ST_LOW) : r.vd_s2;

  // next state of the whole core
  always_comb begin
    next_r = r;
    // two-flop synchronisers, third flop for edge history
    next_r.hd_s1 = horizontal_sync_in_n;
    next_r.hd_s2 = r.hd_s1;
    next_r.hd_q = r.hd_s2;
    next_r.vd_s1 = port_pin_vsync_n;
    next_r.vd_s2 = r.vd_s1;
    next_r.vd_q = r.vd_s2;

    // control writes; bits 7 to 5, 1 and 0 are ignored
    if (ctrl_wr) begin
      next_r.jitter_filter_on = reg_wdata[`JITTER_FILTER_ON_BIT]; // [R6]
      next_r.auto_field_pick = reg_wdata[`AUTO_FIELD_PICK_BIT];
      next_r.vsync_source_sel = reg_wdata[`VSYNC_SOURCE_SEL_BIT];
    end

    // read data valid only in the cycle after the strobe
    next_r.rdata = `READ_NONE;
    if (stat_rd) begin
      next_r.rdata = status;
    end

    // latch results once per vertical sync fall
    if (link.phase_valid) begin
      next_r.phase = link.phase; // [R2] [R13]
      // mid-line fall marks the first-dot field
      next_r.parity = r.auto_field_pick & ~link.near; // [R1] [R3] [R12]
    end
    // clearing the auto bit drops parity whatever the meter says
    if (!r.auto_field_pick) begin
      next_r.parity = 1'b0; // [R12]
    end

    // placement of the internal vertical sync
    case (r.st)
      // idle: a pin fall either drops at once or waits for its slot
      ST_HIGH: begin
        if (vd_fall && r.jitter_filter_on) begin
          if (!vd_near) begin
            next_r.st = ST_LOW; // mid-line fall needs no correction
          end else if (vd_early) begin
            next_r.st = ST_WAIT_QTR; // [R5]
          end else begin
            next_r.st = ST_WAIT_HD; // [R5]
          end
        end
      end
      // late fall: the slot lies in the next line
      ST_WAIT_HD: begin
        if (hd_fall) begin
          next_r.st = ST_WAIT_QTR;
        end
      end
      // drop exactly a quarter line after the hsync fall
      ST_WAIT_QTR: begin
        if (link.pos == qtr) begin
          next_r.st = ST_LOW; // [R5]
        end
      end
      // low until the synchronised pin vsync is released
      ST_LOW: begin
        if (r.vd_s2) begin
          next_r.st = ST_HIGH;
        end
      end
      // illegal codes fall back to idle
      default: begin
        next_r.st = ST_HIGH;
      end
    endcase
    // filter off parks placement so a later enable starts clean
    if (!r.jitter_filter_on) begin
      next_r.st = ST_HIGH;
    end

    // sync outputs and field line decisions for the display
    next_r.hsync_n = r.hd_s2;
    // vsync source select for the display
    next_r.vsync_n = r.vsync_source_sel ? int_vsync_n : r.vd_s2; // [R11]

    // decisions follow the next mode so display and register agree
    if (next_r.auto_field_pick) begin
      next_r.show_first = next_r.parity; // [R7] [R8]
      next_r.show_second = ~next_r.parity; // [R8]
    end else begin
      next_r.show_first = ~next_r.jitter_filter_on; // [R9] [R10]
      next_r.show_second = 1'b1; // [R9] [R10]
    end
  end

  // synchronous reset, every register loads on each edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // registered outputs
  assign reg_rdata = r.rdata;
  assign osd_hsync_n = r.hsync_n;
  assign osd_vsync_n = r.vsync_n;
  assign show_first_dot_lines = r.show_first;
  assign show_second_dot_lines = r.show_second;
  assign field_parity_flag = r.parity;
  assign sync_phase_code = r.phase;
endmodule // sync_jitter_field_decision

// >>> verilog/sync_phase_meter.sv
`timescale 1ns/100ps

module sync_phase_meter (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link to the core
  phase_link_if.meter link
);
  import sync_jitter_pkg::*;

  typedef struct packed {
    count_t pos;
    count_t len;
    phase_t phase;
    logic near;
    logic valid;
  } meter_s;

  localparam meter_s METER_RST = '{
    pos: '0, len: `LINE_LEN_RST, phase: '0, near: 1'b0, valid: 1'b0};

  meter_s r;
  meter_s next_r;

  // line position counter, line length capture, phase at vsync fall
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (link.hd_fall) begin
      next_r.len = (r.pos == `POS_MAX) ? r.pos : r.pos + 12'h001;
      next_r.pos = '0;
    end else if (r.pos != `POS_MAX) begin
      next_r.pos = r.pos + 12'h001;
    end
    if (link.vd_fall) begin
      next_r.phase = phase_of(r.pos, r.len); // [R2] [R4]
      next_r.near = near_hd(r.pos, r.len);
      next_r.valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= METER_RST;
    end else begin
      r <= next_r;
    end
  end

  // results to the core
  assign link.pos = r.pos;
  assign link.len = r.len;
  assign link.phase = r.phase;
  assign link.near = r.near;
  assign link.phase_valid = r.valid;
endmodule // sync_phase_meter
